// *** rtl/ibs_slave.sv ***
// two-wire slave engine with start/stop detection and an apb register file
// assumes scl/sda are open-drain lines pulled up outside; pins are asynchronous
`timescale 1ns/1ps
`include "ibs_map.svh"

module ibs_slave (
  input  wire logic        core_clk_in,    // 100 mhz core clock
  input  wire logic        rst_in,         // async reset, active high
  input  wire logic        psel_in,        // apb select
  input  wire logic        penable_in,     // apb enable
  input  wire logic        pwrite_in,      // apb direction
  input  wire logic [11:0] paddr_in,       // apb byte address
  input  wire logic [31:0] pwdata_in,      // apb write data
  output logic      [31:0] prdata_out,     // apb read data
  output logic             pready_out,     // apb ready
  output logic             pslverr_out,    // apb error on unmapped address
  input  wire logic        scl_in,         // clock line level
  input  wire logic        sda_in,         // data line level
  output logic             scl_out,        // clock drive level, always low
  output logic             scl_oe_out,     // high while pulling clock low
  output logic             sda_out,        // data drive level, always low
  output logic             sda_oe_out      // high while pulling data low
);

  // register index decode, shared by read mux and write strobes
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `IBS_IDX_GIC) | hit(a, `IBS_IDX_PIRQ) | hit(a, `IBS_IDX_BUF) |
             hit(a, `IBS_IDX_CTRL) | hit(a, `IBS_IDX_DIR) | hit(a, `IBS_IDX_PIEN) |
             hit(a, `IBS_IDX_ADDR) | hit(a, `IBS_IDX_STAT);
  endfunction : mapped

  // software-visible state
  logic [7:0] gic_q;
  logic [7:0] pirq_q;
  logic [7:0] pien_q;
  logic [7:0] dir_q;
  logic [7:0] own_addr_q;
  logic [7:0] buf_q;
  logic [3:0] mode_q;
  logic       en_q;
  logic       ckp_q;
  logic       ov_q;
  logic       write_collision_q;
  logic [1:0] smp_cke_q;
  logic       da_q;
  logic       stop_q;
  logic       start_q;
  logic       rw_q;
  logic       ua_q;
  logic       bf_q;

  // engine state
  ibs_pkg::ibs_state_t state_q;
  logic [7:0] sr_q;
  logic [3:0] cnt_q;
  logic       addr_phase_q;
  logic       ten_low_q;
  logic       ten_ok_q;
  logic       match_q;
  logic       ack_q;
  logic       nack_q;

  // apb
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [7:0]  wd;
  logic [7:0]  rd_val;

  assign acc = psel_in & penable_in & pready_q;
  assign wr  = acc & pwrite_in;
  assign rd  = acc & ~pwrite_in;
  assign wd  = pwdata_in[7:0];

  always_comb begin
    rd_val = 8'h00;
    if (hit(paddr_in, `IBS_IDX_GIC))  rd_val = gic_q;
    if (hit(paddr_in, `IBS_IDX_PIRQ)) rd_val = pirq_q;
    if (hit(paddr_in, `IBS_IDX_BUF))  rd_val = buf_q;
    if (hit(paddr_in, `IBS_IDX_CTRL)) rd_val = {write_collision_q, ov_q, en_q, ckp_q, mode_q};
    if (hit(paddr_in, `IBS_IDX_DIR))  rd_val = dir_q;
    if (hit(paddr_in, `IBS_IDX_PIEN)) rd_val = pien_q;
    if (hit(paddr_in, `IBS_IDX_ADDR)) rd_val = own_addr_q;
    if (hit(paddr_in, `IBS_IDX_STAT)) begin
      rd_val = {smp_cke_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q};
    end
  end

  // one wait-free access phase: data and error are captured in the setup cycle
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel_in & ~penable_in & ~pready_q;
      // the error flag stands only beside ready, never past the access cycle
      pslverr_q <= psel_in & ~penable_in & ~pready_q & ~mapped(paddr_in);
      if (psel_in & ~penable_in) prdata_q <= {24'h00_0000, rd_val};
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;

  // plain configuration registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gic_q     <= `IBS_RST_ZERO;
      pien_q    <= `IBS_RST_ZERO;
      dir_q     <= `IBS_RST_DIR;
      mode_q    <= 4'h0;
      en_q      <= 1'b0;
      smp_cke_q <= 2'h0;
    end else if (wr) begin
      if (hit(paddr_in, `IBS_IDX_GIC))  gic_q <= wd;
      if (hit(paddr_in, `IBS_IDX_PIEN)) pien_q <= wd;
      if (hit(paddr_in, `IBS_IDX_DIR))  dir_q <= wd;
      if (hit(paddr_in, `IBS_IDX_STAT)) smp_cke_q <= wd[7:6];
      if (hit(paddr_in, `IBS_IDX_CTRL)) begin
        mode_q <= wd[3:0];
        en_q   <= wd[`IBS_BIT_EN];
      end
    end
  end

  // pin synchronisers: stage one feeds only stage two; stages two and three give edges
  ibs_pkg::ibs_lines_t ln_m;
  ibs_pkg::ibs_lines_t ln_s;
  ibs_pkg::ibs_lines_t ln_p;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ln_m <= 2'h3;
      ln_s <= 2'h3;
      ln_p <= 2'h3;
    end else begin
      ln_m <= '{scl: scl_in, sda: sda_in};
      ln_s <= ln_m;
      ln_p <= ln_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = ln_s.scl & ~ln_p.scl;
  assign scl_fall = ~ln_s.scl & ln_p.scl;
  assign start_ev = ln_s.scl & ln_p.scl & ~ln_s.sda & ln_p.sda;
  assign stop_ev  = ln_s.scl & ln_p.scl & ln_s.sda & ~ln_p.sda;

  // mode decode
  logic slave_on;
  logic ten_mode;
  logic ss_irq;
  assign slave_on = en_q & ((mode_q == `IBS_MODE_S7) | (mode_q == `IBS_MODE_S10) |
                            (mode_q == `IBS_MODE_S7I) | (mode_q == `IBS_MODE_S10I));
  assign ten_mode = (mode_q == `IBS_MODE_S10) | (mode_q == `IBS_MODE_S10I);
  assign ss_irq   = en_q & ((mode_q == `IBS_MODE_FWM) | (mode_q == `IBS_MODE_S7I) |
                            (mode_q == `IBS_MODE_S10I));

  // address comparison at the end of the eighth bit
  logic match;
  logic ten_hdr;
  always_comb begin
    ten_hdr = (sr_q[7:3] == `IBS_TEN_HDR) && (sr_q[2:1] == own_addr_q[2:1]);
    if (!addr_phase_q) begin
      match = 1'b1;
    end else if (!ten_mode) begin
      match = (sr_q[7:1] == own_addr_q[7:1]);
    end else if (ten_low_q) begin
      match = (sr_q == own_addr_q);
    end else begin
      // a read header is only honoured after the full address matched earlier
      match = ten_hdr & (~sr_q[0] | ten_ok_q);
    end
  end

  logic byte_done;
  logic wr_buf;
  logic wr_ctrl;
  logic wr_pirq;
  assign byte_done = scl_fall & (cnt_q == `IBS_BITS_BYTE);
  assign wr_buf    = wr & hit(paddr_in, `IBS_IDX_BUF);
  assign wr_ctrl   = wr & hit(paddr_in, `IBS_IDX_CTRL);
  assign wr_pirq   = wr & hit(paddr_in, `IBS_IDX_PIRQ);

  // engine and the flags it shares with software; hardware sets come last so they win
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q      <= ibs_pkg::ST_IDLE;
      sr_q         <= 8'h00;
      cnt_q        <= 4'h0;
      addr_phase_q <= 1'b0;
      ten_low_q    <= 1'b0;
      ten_ok_q     <= 1'b0;
      match_q      <= 1'b0;
      ack_q        <= 1'b0;
      nack_q       <= 1'b0;
      pirq_q       <= `IBS_RST_ZERO;
      own_addr_q   <= `IBS_RST_ZERO;
      buf_q        <= 8'h00;
      ckp_q        <= 1'b0;
      ov_q         <= 1'b0;
      write_collision_q       <= 1'b0;
      da_q         <= 1'b0;
      stop_q       <= 1'b0;
      start_q      <= 1'b0;
      rw_q         <= 1'b0;
      ua_q         <= 1'b0;
      bf_q         <= 1'b0;
    end else begin
      // software side
      if (wr_pirq) pirq_q <= wd;
      if (wr_ctrl) begin
        write_collision_q <= wd[`IBS_BIT_WRITE_COLLISION];
        ov_q   <= wd[`IBS_BIT_OV];
        ckp_q  <= wd[`IBS_BIT_CKP];
      end
      if (wr & hit(paddr_in, `IBS_IDX_ADDR)) begin
        own_addr_q <= wd;
        ua_q       <= 1'b0;
      end
      if (rd & hit(paddr_in, `IBS_IDX_BUF)) bf_q <= 1'b0;
      if (wr_buf) begin
        buf_q <= wd;
        // a write while bits are going out would corrupt the byte
        if (state_q == ibs_pkg::ST_TX) write_collision_q <= 1'b1;
        else sr_q <= wd;
      end

      // bus condition tracking
      if (!en_q) begin
        start_q <= 1'b0;
        stop_q  <= 1'b0;
      end else if (start_ev) begin
        start_q <= 1'b1;
        stop_q  <= 1'b0;
      end else if (stop_ev) begin
        stop_q  <= 1'b1;
        start_q <= 1'b0;
      end
      if (ss_irq & (start_ev | stop_ev)) pirq_q[`IBS_BIT_IRQ] <= 1'b1;

      // slave sequencer
      if (!slave_on) begin
        state_q  <= ibs_pkg::ST_IDLE;
        ten_ok_q <= 1'b0;
        ack_q    <= 1'b0;
      end else if (start_ev) begin
        // a start restarts reception from any state, even while this device is transmitting
        state_q      <= ibs_pkg::ST_RX;
        cnt_q        <= 4'h0;
        addr_phase_q <= 1'b1;
        ten_low_q    <= 1'b0;
        ack_q        <= 1'b0;
      end else if (stop_ev) begin
        state_q  <= ibs_pkg::ST_IDLE;
        ten_ok_q <= 1'b0;
        ack_q    <= 1'b0;
      end else begin
        unique case (state_q)
          ibs_pkg::ST_IDLE: begin
            cnt_q <= 4'h0;
          end
          ibs_pkg::ST_RX: begin
            if (scl_rise) begin
              sr_q  <= {sr_q[6:0], ln_s.sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_done) begin
              match_q <= match;
              ack_q   <= match & ~bf_q & ~ov_q;
              state_q <= match ? ibs_pkg::ST_ACK : ibs_pkg::ST_IDLE;
            end
          end
          ibs_pkg::ST_ACK: begin
            if (scl_fall) begin
              ack_q <= 1'b0;
              cnt_q <= 4'h0;
              pirq_q[`IBS_BIT_IRQ] <= 1'b1;
              if (ack_q) begin
                buf_q <= sr_q;
                bf_q  <= 1'b1;
              end else if (bf_q) begin
                ov_q <= 1'b1;
              end
              if (addr_phase_q) begin
                // the ten-bit low byte carries no direction bit
                if (~(ten_mode & ten_low_q)) rw_q <= sr_q[0];
                da_q <= 1'b0;
              end else begin
                da_q <= 1'b1;
              end
              if (!ack_q) begin
                state_q <= ibs_pkg::ST_IDLE;
              end else if (addr_phase_q & sr_q[0] & ~(ten_mode & ten_low_q)) begin
                ckp_q   <= 1'b0;
                state_q <= ibs_pkg::ST_TXW;
              end else if (addr_phase_q & ten_mode) begin
                ua_q      <= 1'b1;
                ten_low_q <= ~ten_low_q;
                ten_ok_q  <= ten_low_q;
                // the high byte is followed by the low address byte
                addr_phase_q <= ~ten_low_q;
                state_q      <= ibs_pkg::ST_RX;
              end else begin
                addr_phase_q <= 1'b0;
                state_q      <= ibs_pkg::ST_RX;
              end
            end
          end
          ibs_pkg::ST_TXW: begin
            if (ckp_q) begin
              state_q <= ibs_pkg::ST_TX;
              cnt_q   <= 4'h0;
            end
          end
          ibs_pkg::ST_TX: begin
            if (scl_fall) begin
              sr_q  <= {sr_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `IBS_BITS_BYTE - 4'h1) state_q <= ibs_pkg::ST_TXACK;
            end
          end
          ibs_pkg::ST_TXACK: begin
            if (scl_rise) begin
              nack_q <= ln_s.sda;
            end else if (scl_fall) begin
              pirq_q[`IBS_BIT_IRQ] <= 1'b1;
              if (nack_q) begin
                // transfer over: status returns to its idle view
                rw_q    <= 1'b0;
                da_q    <= 1'b0;
                ua_q    <= 1'b0;
                bf_q    <= 1'b0;
                state_q <= ibs_pkg::ST_IDLE;
              end else begin
                ckp_q   <= 1'b0;
                state_q <= ibs_pkg::ST_TXW;
              end
            end
          end
        endcase
      end
    end
  end

  // open-drain pin drive; the high level always comes from the pull-ups
  logic scl_oe_d;
  logic sda_oe_d;
  logic scl_oe_q;
  logic sda_oe_q;
  logic pin_lo_q;

  always_comb begin
    scl_oe_d = ~dir_q[`IBS_BIT_SCLDIR];
    if (ua_q) scl_oe_d = 1'b1;
    if ((state_q == ibs_pkg::ST_TXW) & ~ckp_q) scl_oe_d = 1'b1;
    sda_oe_d = ~dir_q[`IBS_BIT_SDADIR];
    if ((state_q == ibs_pkg::ST_ACK) & ack_q) sda_oe_d = 1'b1;
    if ((state_q == ibs_pkg::ST_TX) & ~sr_q[7]) sda_oe_d = 1'b1;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      pin_lo_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      pin_lo_q <= 1'b0;
    end
  end

  assign scl_oe_out = scl_oe_q;
  assign sda_oe_out = sda_oe_q;
  assign scl_out    = pin_lo_q;
  assign sda_out    = pin_lo_q;

endmodule : ibs_slave

// *** common/ibs_map.svh ***
// register map, field positions, reset values and mode codes for the two-wire slave engine
// assumes a 32-bit apb slave where each register index sits at byte address index*4
`ifndef IBS_MAP_SVH
`define IBS_MAP_SVH

`define IBS_IDX_GIC      8'h0b
`define IBS_IDX_PIRQ     8'h0c
`define IBS_IDX_BUF      8'h13
`define IBS_IDX_CTRL     8'h14
`define IBS_IDX_DIR      8'h87
`define IBS_IDX_PIEN     8'h8c
`define IBS_IDX_ADDR     8'h93
`define IBS_IDX_STAT     8'h94

`define IBS_RST_DIR      8'hff
`define IBS_RST_ZERO     8'h00

`define IBS_BIT_IRQ      3
`define IBS_BIT_WRITE_COLLISION     7
`define IBS_BIT_OV       6
`define IBS_BIT_EN       5
`define IBS_BIT_CKP      4
`define IBS_BIT_SCLDIR   3
`define IBS_BIT_SDADIR   4

`define IBS_MODE_S7      4'h6
`define IBS_MODE_S10     4'h7
`define IBS_MODE_FWM     4'hb
`define IBS_MODE_S7I     4'he
`define IBS_MODE_S10I    4'hf

`define IBS_TEN_HDR      5'h1e
`define IBS_BITS_BYTE    4'h8

`endif

// *** common/ibs_pkg.sv ***
// types shared by the two-wire slave engine
// assumes the constants in ibs_map.svh
package ibs_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RX    = 6'b000010,
    ST_ACK   = 6'b000100,
    ST_TXW   = 6'b001000,
    ST_TX    = 6'b010000,
    ST_TXACK = 6'b100000
  } ibs_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ibs_lines_t;

endpackage : ibs_pkg

// *** test/ibs_slave_monitor.sv ***
// concurrent checks on the apb and pin ports of the two-wire slave
// assumes it is bound to ibs_slave; one clock domain
`timescale 1ns/1ps
module ibs_slave_monitor (
  input wire logic        core_clk_in, // clock
  input wire logic        rst_in,      // reset
  input wire logic        psel_in,     // select
  input wire logic        penable_in,  // enable
  input wire logic        pwrite_in,   // direction
  input wire logic [31:0] prdata_out,  // read data
  input wire logic        pready_out,  // ready
  input wire logic        pslverr_out, // error
  input wire logic        scl_in,      // clock line
  input wire logic        scl_out,     // clock level
  input wire logic        scl_oe_out,  // clock pull
  input wire logic        sda_out,     // data level
  input wire logic        sda_oe_out   // data pull
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire logic wr_done = psel_in && penable_in && pready_out && pwrite_in;
  sequence setup_s; psel_in && !penable_in; endsequence
  sequence answer_s; pready_out ##1 !pready_out; endsequence
  ready_once_a: assert property (setup_s |=> answer_s)
    else $error("ready not one cycle after setup");
  ready_phase_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access phase");
  err_read_a: assert property (pslverr_out && !pwrite_in |-> pready_out && prdata_out == 32'h0)
    else $error("refused read not zero");
  upper_zero_a: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  low_only_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin level driven high");
  // a slave data change while the clock is high would look like start or stop
  sda_move_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data pull moved while clock high");
  release_cause_a: assert property ($fell(scl_oe_out) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("clock released without a register write");
  reset_quiet_a: assert property ($fell(rst_in) |-> !scl_oe_out && !sda_oe_out)
    else $error("pins pulled right after reset");
endmodule : ibs_slave_monitor

// *** test/ibs_master_model.sv ***
// behavioural bus master on the far side of the slave
// assumes open-drain lines resolved with pull-ups by the bench
`timescale 1ns/1ps
module ibs_master_model (
  input  wire logic scl_in,  // resolved clock line
  input  wire logic sda_in,  // resolved data line
  output logic      scl_out, // 0 pulls clock low
  output logic      sda_out  // 0 pulls data low
);
  localparam realtime Q = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_out = b;
    #Q scl_out = 1'b1;
    wait (scl_in === 1'b1);
    #Q r = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask : bit_io
  task automatic start_c;
    sda_out = 1'b1;
    #Q scl_out = 1'b1;
    wait (scl_in === 1'b1);
    #Q sda_out = 1'b0;
    #Q scl_out = 1'b0;
    #Q;
  endtask : start_c
  task automatic stop_c;
    sda_out = 1'b0;
    #Q scl_out = 1'b1;
    wait (scl_in === 1'b1);
    #Q sda_out = 1'b1;
    #Q;
  endtask : stop_c
  // msb first; mack is the master's own ninth bit, ack what the line showed
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(mack, ack);
  endtask : xfer
endmodule : ibs_master_model

// *** test/tb_ibs_slave.sv ***
// self-checking bench for the two-wire slave: apb tasks, bus master model, read queue
// assumes ibs_master_model and ibs_slave_monitor are compiled first
`timescale 1ns/1ps
`include "ibs_map.svh"
module tb_ibs_slave;
  localparam logic [7:0] ST = `IBS_IDX_STAT, IR = `IBS_IDX_PIRQ, BU = `IBS_IDX_BUF;
  localparam logic [7:0] CT = `IBS_IDX_CTRL, AD = `IBS_IDX_ADDR;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] seed = 32'h6133;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
  wire         scl = m_scl & ~scl_oe;
  wire         sda = m_sda & ~sda_oe;
  int          fails = 0, n_checks = 0, cyc = 0;
  logic [16:0] exp_q[$];
  logic [7:0]  adr, d1, r;
  logic [3:0]  m;
  logic        ack;
  logic [7:0]  idx[6] = '{IR, CT, `IBS_IDX_DIR, `IBS_IDX_PIEN, AD, ST};
  logic [7:0]  rv[6] = '{8'h00, 8'h00, `IBS_RST_DIR, 8'h00, 8'h00, 8'h00};
  logic [3:0]  modes[5] = '{`IBS_MODE_S7, `IBS_MODE_S10, `IBS_MODE_S7I, `IBS_MODE_S10I,
                            `IBS_MODE_FWM};
  always #5 core_clk_in = ~core_clk_in;
  ibs_slave u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl),
    .sda_in(sda), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe));
  ibs_master_model u_mst (.scl_in(scl), .sda_in(sda), .scl_out(m_scl), .sda_out(m_sda));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic complete_run;
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic chk_reg(input logic [16:0] e);
    n_checks++;
    if ({pslverr, prdata[31:8], prdata[7:0] & e[15:8]} !== {e[16], 24'h0, e[7:0] & e[15:8]}) begin
      fails++;
      $display("BAD %0t read %h at %h", $time, prdata, paddr);
    end
  endtask : chk_reg
  task automatic chk_link(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t link %h want %h", $time, g, e);
    end
  endtask : chk_link
  task automatic apb(input logic [7:0] i, input logic w, input logic [7:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk_in);
    penable <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(i, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] mk, input logic [7:0] e);
    exp_q.push_back({(i == 8'h01), mk, e});
    apb(i, 1'b0, 8'h00);
  endtask : rd
  // read results are judged where they appear, against the oldest note
  always @(posedge core_clk_in) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk_reg(exp_q.pop_front());
    end
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int k = 0; k < 6; k++) rd(idx[k], 8'hff, rv[k]);
    wr(8'h01, 8'h5a);
    rd(8'h01, 8'hff, 8'h00);
    seed = lfsr(seed);
    adr = {2'b01, seed[4:0], 1'b0};
    wr(AD, adr);
    rd(AD, 8'hff, adr);
    wr(CT, 8'h36);
    u_mst.start_c();
    u_mst.xfer(adr, 1'b1, r, ack);
    chk_link(8'(ack), 8'h00);
    rd(ST, 8'h2d, 8'h09);
    rd(BU, 8'hff, adr);
    rd(ST, 8'h01, 8'h00);
    rd(IR, 8'h08, 8'h08);
    wr(IR, 8'h00);
    seed = lfsr(seed);
    d1 = seed[7:0];
    u_mst.xfer(d1, 1'b1, r, ack);
    chk_link(8'(ack), 8'h00);
    u_mst.xfer(~d1, 1'b1, r, ack);
    chk_link(8'(ack), 8'h01);
    rd(CT, 8'hff, 8'h76);
    rd(ST, 8'h21, 8'h21);
    rd(IR, 8'h08, 8'h08);
    rd(BU, 8'hff, d1);
    u_mst.stop_c();
    rd(CT, 8'h40, 8'h40);
    u_mst.start_c();
    u_mst.xfer(adr, 1'b1, r, ack);
    chk_link(8'(ack), 8'h01);
    u_mst.stop_c();
    wr(CT, 8'h36);
    u_mst.start_c();
    u_mst.xfer(adr ^ 8'h02, 1'b1, r, ack);
    chk_link(8'(ack), 8'h01);
    u_mst.stop_c();
    wr(IR, 8'h00);
    u_mst.start_c();
    u_mst.xfer(adr | 8'h01, 1'b1, r, ack);
    chk_link(8'(ack), 8'h00);
    rd(ST, 8'h05, 8'h05);
    rd(CT, 8'h10, 8'h00);
    chk_link(8'(scl_oe), 8'h01);
    rd(BU, 8'hff, adr | 8'h01);
    seed = lfsr(seed);
    wr(BU, seed[7:0]);
    wr(CT, 8'h36);
    u_mst.xfer(8'hff, 1'b1, r, ack);
    chk_link(r, seed[7:0]);
    rd(ST, 8'h07, 8'h00);
    rd(IR, 8'h08, 8'h08);
    u_mst.stop_c();
    wr(AD, 8'hf2);
    wr(CT, 8'h37);
    u_mst.start_c();
    u_mst.xfer(8'hf2, 1'b1, r, ack);
    chk_link(8'(ack), 8'h00);
    rd(ST, 8'h03, 8'h03);
    chk_link(8'(scl_oe), 8'h01);
    rd(BU, 8'h00, 8'h00);
    seed = lfsr(seed);
    wr(AD, seed[7:0]);
    u_mst.xfer(seed[7:0], 1'b1, r, ack);
    chk_link(8'(ack), 8'h00);
    rd(ST, 8'h03, 8'h03);
    wr(AD, 8'hf2);
    rd(ST, 8'h02, 8'h00);
    rd(BU, 8'h00, 8'h00);
    u_mst.start_c();
    u_mst.xfer(8'hf3, 1'b1, r, ack);
    chk_link(8'(ack), 8'h00);
    rd(ST, 8'h05, 8'h05);
    seed = lfsr(seed);
    wr(BU, seed[7:0]);
    wr(CT, 8'h37);
    u_mst.xfer(8'hff, 1'b1, r, ack);
    chk_link(r, seed[7:0]);
    u_mst.stop_c();
    wr(AD, adr);
    for (int k = 0; k < 5; k++) begin
      m = modes[k];
      wr(CT, {4'h3, m});
      wr(IR, 8'h00);
      u_mst.start_c();
      rd(ST, 8'h18, 8'h08);
      rd(IR, 8'h08, {4'h0, m[3], 3'h0});
      u_mst.xfer(adr, 1'b1, r, ack);
      chk_link(8'(ack), 8'(m[2:0] != 3'b110));
      rd(BU, 8'h00, 8'h00);
      wr(IR, 8'h00);
      u_mst.stop_c();
      rd(ST, 8'h18, 8'h10);
      rd(IR, 8'h08, {4'h0, m[3], 3'h0});
    end
    wr(`IBS_IDX_DIR, 8'hf7);
    repeat (2) @(posedge core_clk_in);
    chk_link(8'(scl_oe), 8'h01);
    wr(`IBS_IDX_DIR, `IBS_RST_DIR);
    wr(CT, 8'h00);
    rd(ST, 8'h18, 8'h00);
    repeat (4) @(posedge core_clk_in);
    complete_run();
  end
endmodule : tb_ibs_slave

bind ibs_slave ibs_slave_monitor u_mon (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
